// file: verilog/scl_loader.sv
/*
 * Strap configuration loader: reads straps at start-up, holds settings.
 * Assumes start_up pulses once per start-up and inputs are synchronous.
 */
// Function
// R1: Straps are sampled only during start-up, ignored afterwards.
// R2: No strap detected keeps factory default settings.
// R3: Strapped settings stay writable by later serial commands.
// R4: Non-setpoint straps resolve into sixteen indexes incl. short and open.
// R5: Strap readings are filtered before resolving.
// R6: Set-point equals strap resistance divided by 18.75 kilohm, in volts.
// R7: Shorted or open setpoint strap keeps 0.6 volt default.
// R8: Setpoint strap also selects initial control pin behaviour.
// R9: Both address straps open gives address 0x10.
// R10: High strap shorted gives address 16 plus low index.
// R11: High index 0..6 gives 16 times (1+high) plus low.
// R12: Decoded address never falls in 0..15.
// R13: Integrator gives each device a unique strapped address.
// R14: Settings latched at end of start-up, held until restart or write.
`timescale 1ns/1ns
module scl_loader import scl_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start_up,
	input wire logic [RES_W-1:0] low_address_resistor,
	input wire logic [RES_W-1:0] high_address_resistor,
	input wire logic [RES_W-1:0] setpoint_resistor,
	input wire logic wr_addr_valid,
	input wire logic [6:0] wr_addr,
	input wire logic wr_vout_valid,
	input wire logic [VOUT_W-1:0] wr_vout_mv,
	input wire logic wr_ctrl_valid,
	input wire logic [1:0] wr_ctrl_mode,
	output logic [6:0] slave_address,
	output logic [VOUT_W-1:0] vout_setpoint_mv,
	output logic [1:0] ctrl_mode,
	output logic straps_detected,
	output logic config_ready
);
	scl_strap_if sif ();

	scl_state_t st_q, st_d;
	logic [DIV_W-1:0] div_q, div_d;
	logic sample_en_q, sample_en_d;
	logic [6:0] addr_q, addr_d;
	logic [VOUT_W-1:0] vout_q, vout_d;
	scl_ctrl_t ctrl_q, ctrl_d;
	logic det_q, det_d;
	logic ready_q, ready_d;
	logic [3:0] lo_idx, hi_idx;
	logic [RES_W-1:0] vs;
	logic vs_short, vs_open;
	logic [VOUT_W-1:0] vs_mv;

	scl_strap_filter u_filter (
		.clk(clk),
		.reset_n(reset_n),
		.sif(sif.filt)
	);

	// R1: only start-up opens a sampling window
	assign sif.start = start_up;
	assign sif.sample_en = sample_en_q;
	assign sif.raw[CH_LOW] = low_address_resistor;
	assign sif.raw[CH_HIGH] = high_address_resistor;
	assign sif.raw[CH_SET] = setpoint_resistor;

	// R4: sixteen index codes per address strap
	assign lo_idx = scl_strap_index(sif.avg[CH_LOW]);
	assign hi_idx = scl_strap_index(sif.avg[CH_HIGH]);
	assign vs = sif.avg[CH_SET];
	// R7: short and open limits
	assign vs_short = vs < SHORT_MAX_OHM;
	assign vs_open = vs > OPEN_MIN_OHM;
	// R6: resistance over 18.75 kilohm, in millivolts
	assign vs_mv = VOUT_W'(({2'b00, vs} * 19'(VSET_MUL)) / 19'(VSET_DIV));

	always_comb
	begin
		div_d = div_q + 1'b1;
		sample_en_d = 1'b0;
		if (div_q == DIV_LAST)
		begin
			div_d = '0;
			sample_en_d = 1'b1;
		end
	end

	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: st_d = st_q;
			ST_SAMPLE:
			begin
				if (sif.done)
					st_d = ST_LATCH;
			end
			ST_LATCH: st_d = ST_RUN;
			ST_RUN: st_d = st_q;
		endcase
		if (start_up)
			st_d = ST_SAMPLE;
	end

	always_comb
	begin
		addr_d = addr_q;
		vout_d = vout_q;
		ctrl_d = ctrl_q;
		det_d = det_q;
		ready_d = (st_d == ST_RUN);
		if (st_q == ST_LATCH)
		begin
			// R14: latch resolved settings once
			// R2: undetected straps leave defaults
			det_d = (lo_idx != IDX_OPEN) || (hi_idx != IDX_OPEN) || !vs_open;
			// R9: R10: R11: R12: address from index pair
			addr_d = scl_addr_decode(lo_idx, hi_idx);
			// R6: R7: set-point from setpoint strap
			vout_d = (vs_short || vs_open) ? DEF_VOUT_MV : vs_mv;
			// R8: control pin behaviour from setpoint strap
			if (vs_short)
				ctrl_d = CTRL_ALWAYS_ON;
			else if (vs_open)
				ctrl_d = DEF_CTRL;
			else
				ctrl_d = CTRL_ACT_LOW;
		end
		else if (st_q == ST_RUN && !start_up)
		begin
			// R3: serial overwrite in normal operation
			if (wr_addr_valid)
				addr_d = wr_addr;
			if (wr_vout_valid)
				vout_d = wr_vout_mv;
			if (wr_ctrl_valid && wr_ctrl_mode != 2'b11)
				ctrl_d = scl_ctrl_t'(wr_ctrl_mode);
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q <= ST_IDLE;
			div_q <= '0;
			sample_en_q <= 1'b0;
			addr_q <= DEF_ADDR;
			vout_q <= DEF_VOUT_MV;
			ctrl_q <= DEF_CTRL;
			det_q <= 1'b0;
			ready_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			div_q <= div_d;
			sample_en_q <= sample_en_d;
			addr_q <= addr_d;
			vout_q <= vout_d;
			ctrl_q <= ctrl_d;
			det_q <= det_d;
			ready_q <= ready_d;
		end
	end

	assign slave_address = addr_q;
	assign vout_setpoint_mv = vout_q;
	assign ctrl_mode = ctrl_q;
	assign straps_detected = det_q;
	assign config_ready = ready_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Serial writes may legally leave the strap range, so only the latch is judged
	a_addr_not_reserved: assert property (st_q == ST_LATCH |=> addr_q >= ADDR_BASE) // R12
		else $error("slave address in reserved range");
	a_run_holds_config: assert property ( // R1
		st_q == ST_RUN && !start_up && !wr_addr_valid && !wr_vout_valid && !wr_ctrl_valid
		|=> $stable(addr_q) && $stable(vout_q) && $stable(ctrl_q))
		else $error("settings changed outside start-up");
	a_latch_ready: assert property ( // R14
		st_q == ST_LATCH && !start_up |=> config_ready && st_q == ST_RUN)
		else $error("latch not followed by ready");
	a_open_default_addr: assert property ( // R9
		st_q == ST_LATCH && lo_idx == IDX_OPEN && hi_idx == IDX_OPEN |=> addr_q == 7'h10)
		else $error("open address straps not 0x10");
	a_low_only_addr: assert property ( // R10
		st_q == ST_LATCH && hi_idx == IDX_SHORT
		|=> addr_q == 7'h10 + {3'h0, $past(lo_idx)})
		else $error("low strap address wrong");
	a_both_addr: assert property ( // R11
		st_q == ST_LATCH && hi_idx <= HI_IDX_MAX
		|=> addr_q == 7'(16 * (1 + $past(hi_idx)) + $past(lo_idx)))
		else $error("two strap address wrong");
	a_vset_default: assert property ( // R7
		st_q == ST_LATCH && (vs_short || vs_open) |=> vout_q == 13'h0258)
		else $error("set-point not default");
	a_vset_ratio: assert property ( // R6
		st_q == ST_LATCH && !vs_short && !vs_open
		|=> 32'(vout_q) * 75 <= 32'($past(vs)) * 4
		&& 32'($past(vs)) * 4 < (32'(vout_q) + 1) * 75)
		else $error("set-point ratio wrong");
	a_ctrl_by_vset: assert property ( // R8
		st_q == ST_LATCH && !vs_short && !vs_open |=> ctrl_q == CTRL_ACT_LOW)
		else $error("control mode not from setpoint strap");
	a_serial_write: assert property ( // R3
		st_q == ST_RUN && !start_up && wr_addr_valid |=> addr_q == $past(wr_addr))
		else $error("serial address write lost");
	a_no_strap_default: assert property ( // R2
		st_q == ST_LATCH && !det_d |=> !straps_detected && addr_q == DEF_ADDR
		&& vout_q == DEF_VOUT_MV && ctrl_q == DEF_CTRL)
		else $error("defaults not kept without straps");
	a_filter_window: assert property ( // R5
		start_up ##1 (!start_up)[*8] |-> st_q == ST_SAMPLE)
		else $error("sampling ended before filter");

	c_strap_latch: cover property (st_q == ST_LATCH && det_d);
	c_serial_write: cover property (st_q == ST_RUN && wr_addr_valid);
	c_restart: cover property (st_q == ST_SAMPLE && start_up);
	c_default_latch: cover property (st_q == ST_LATCH && !det_d);
endmodule

// file: include/scl_pkg.sv
/*
 * Constants, types and decode functions of the strap configuration loader.
 * Assumes strap resistances arrive as measured values in ohms.
 */
package scl_pkg;
	localparam int RES_W = 17;
	localparam int N_STRAP = 3;
	localparam int CH_LOW = 0;
	localparam int CH_HIGH = 1;
	localparam int CH_SET = 2;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SAMPLE_PERIOD_NS = 1000;
	localparam int SAMPLE_DIV = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIV_W = 7;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);
	localparam int FILT_SHIFT = 3;
	localparam logic [FILT_SHIFT-1:0] FILT_LAST = 3'h7;
	localparam int SUM_W = RES_W + FILT_SHIFT;
	localparam logic [RES_W-1:0] SHORT_MAX_OHM = 17'h0000a;
	localparam logic [RES_W-1:0] OPEN_MIN_OHM = 17'h15f90;
	localparam int VOUT_W = 13;
	localparam int VSET_MUL = 4;
	localparam int VSET_DIV = 75;
	localparam logic [VOUT_W-1:0] DEF_VOUT_MV = 13'h0258;
	localparam logic [6:0] DEF_ADDR = 7'h10;
	localparam logic [6:0] ADDR_BASE = 7'h10;
	localparam logic [3:0] IDX_SHORT = 4'h0;
	localparam logic [3:0] IDX_OPEN = 4'hf;
	localparam logic [3:0] HI_IDX_MAX = 4'h6;
	// Boundaries between the sixteen standard strap values
	localparam logic [RES_W-1:0] IDX_BOUND [15] = '{
		17'h00d48, 17'h01d4c, 17'h0238c, 17'h02af8, 17'h034bc,
		17'h04074, 17'h04e20, 17'h05fb4, 17'h07530, 17'h08ca0,
		17'h0a7f8, 17'h0c92c, 17'h0f230, 17'h124f8, 17'h16378};

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_LATCH = 2'b10,
		ST_RUN = 2'b11
	} scl_state_t;

	typedef enum logic [1:0] {
		CTRL_ALWAYS_ON = 2'b00,
		CTRL_ACT_HIGH = 2'b01,
		CTRL_ACT_LOW = 2'b10
	} scl_ctrl_t;

	localparam scl_ctrl_t DEF_CTRL = CTRL_ACT_HIGH;

	function automatic logic [3:0] scl_strap_index(input logic [RES_W-1:0] r);
		logic [3:0] idx;
		idx = IDX_SHORT;
		for (int i = 0; i < 15; i++)
		begin
			if (r >= IDX_BOUND[i])
				idx = 4'(i + 1);
		end
		return idx;
	endfunction

	function automatic logic [6:0] scl_addr_decode(input logic [3:0] lo, input logic [3:0] hi);
		logic [6:0] a;
		if (hi <= HI_IDX_MAX)
			a = ADDR_BASE + {hi[2:0], 4'h0} + {3'h0, lo};
		else if (lo == IDX_OPEN)
			a = DEF_ADDR;
		else
			a = ADDR_BASE + {3'h0, lo};
		return a;
	endfunction
endpackage

// file: include/scl_strap_if.sv
/*
 * Carrier between the loader and its strap filter.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ns
interface scl_strap_if;
	import scl_pkg::*;
	logic start;
	logic sample_en;
	logic [RES_W-1:0] raw [N_STRAP];
	logic [RES_W-1:0] avg [N_STRAP];
	logic done;

	modport filt (input start, input sample_en, input raw, output avg, output done);
	modport ctrl (output start, output sample_en, output raw, input avg, input done);
endinterface

// file: verilog/scl_strap_filter.sv
/*
 * Averages each strap reading over a fixed number of sample pulses.
 * Assumes start is a one-cycle pulse and raw readings are synchronous.
 */
`timescale 1ns/1ns
module scl_strap_filter import scl_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	scl_strap_if.filt sif
);
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic [FILT_SHIFT-1:0] cnt_q, cnt_d;

	always_comb
	begin
		busy_d = busy_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		if (sif.start)
		begin
			busy_d = 1'b1;
			cnt_d = '0;
		end
		else if (busy_q && sif.sample_en)
		begin
			cnt_d = cnt_q + 1'b1;
			if (cnt_q == FILT_LAST)
			begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			cnt_q <= '0;
		end
		else
		begin
			busy_q <= busy_d;
			done_q <= done_d;
			cnt_q <= cnt_d;
		end
	end

	assign sif.done = done_q;

	// R5: averaging filter
	for (genvar g = 0; g < N_STRAP; g++)
	begin : g_ch
		logic [SUM_W-1:0] sum_q, sum_d, avg_q, avg_d;

		always_comb
		begin
			sum_d = sum_q;
			avg_d = avg_q;
			if (sif.start)
				sum_d = '0;
			else if (busy_q && sif.sample_en)
			begin
				sum_d = sum_q + {{FILT_SHIFT{1'b0}}, sif.raw[g]};
				if (cnt_q == FILT_LAST)
					avg_d = sum_d >> FILT_SHIFT;
			end
		end

		always_ff @(posedge clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				sum_q <= '0;
				avg_q <= '0;
			end
			else
			begin
				sum_q <= sum_d;
				avg_q <= avg_d;
			end
		end

		assign sif.avg[g] = avg_q[RES_W-1:0];
	end
endmodule

// file: bench/scl_strap_model.sv
/*
 * Strap resistor model: turns strap index codes into measured ohms.
 * Assumes the bench picks the index codes and the raw setpoint value.
 */
`timescale 1ns/1ns
module scl_strap_model import scl_pkg::*; (
	input wire logic [3:0] low_index,
	input wire logic [3:0] high_index,
	input wire logic [RES_W-1:0] setpoint_ohm,
	output logic [RES_W-1:0] low_address_resistor,
	output logic [RES_W-1:0] high_address_resistor,
	output logic [RES_W-1:0] setpoint_resistor
);
	// one strap code pair per device
	function automatic logic [RES_W-1:0] scl_std_ohm(input logic [3:0] i);
		logic [RES_W-1:0] tbl [16];
		tbl = '{17'h00000, 17'h01a90, 17'h02008, 17'h02710, 17'h02ee0, 17'h03a98,
			17'h04650, 17'h055f0, 17'h06978, 17'h080e8, 17'h09858, 17'h0b798,
			17'h0dac0, 17'h109a0, 17'h14050, 17'h186a0};
		return tbl[i];
	endfunction
	assign low_address_resistor = scl_std_ohm(low_index);
	assign high_address_resistor = scl_std_ohm(high_index);
	assign setpoint_resistor = setpoint_ohm;
endmodule

// file: bench/test_strap_config_loader.sv
/*
 * Self-checking bench of the strap configuration loader.
 * Assumes straps come from the strap model and writes from this bench.
 */
`timescale 1ns/1ns
module test_strap_config_loader import scl_pkg::*;;
	logic clk = 0, reset_n = 0, start_up = 0;
	logic [3:0] lo_i = 4'hf, hi_i = 4'hf;
	logic [RES_W-1:0] set_r = 17'h186a0;
	logic [RES_W-1:0] lo_r, hi_r, sp_r;
	logic wa_v = 0, wv_v = 0, wc_v = 0;
	logic [6:0] wa = 7'h00, addr;
	logic [VOUT_W-1:0] wv = 13'h0000, vout;
	logic [1:0] wc = 2'h0, mode;
	logic det, rdy;
	int mismatches = 0, compares = 0;
	always #4 clk = ~clk;
	scl_strap_model strap_u (.low_index(lo_i), .high_index(hi_i), .setpoint_ohm(set_r),
		.low_address_resistor(lo_r), .high_address_resistor(hi_r), .setpoint_resistor(sp_r));
	scl_loader dut_u (.clk(clk), .reset_n(reset_n), .start_up(start_up),
		.low_address_resistor(lo_r), .high_address_resistor(hi_r), .setpoint_resistor(sp_r),
		.wr_addr_valid(wa_v), .wr_addr(wa), .wr_vout_valid(wv_v), .wr_vout_mv(wv),
		.wr_ctrl_valid(wc_v), .wr_ctrl_mode(wc), .slave_address(addr),
		.vout_setpoint_mv(vout), .ctrl_mode(mode), .straps_detected(det), .config_ready(rdy));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic boot();
		int n;
		n = 0;
		@(posedge clk) start_up <= 1;
		@(posedge clk) start_up <= 0;
		#1 check("ready drop", rdy, 1'b0);
		while (rdy !== 1'b1 && n < 1200)
		begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 1200)
		begin
			mismatches++;
			results();
		end
		check("filter time", n >= 7 * 125, 1'b1);
		check("filter end", n <= 8 * 125 + 3, 1'b1);
	endtask
	task automatic test_defaults();
		check("reset addr", addr, 7'h10);
		check("reset vout", vout, 13'h0258);
		boot();
		check("open addr", addr, 7'h10);
		check("open vout", vout, 13'h0258);
		check("open mode", mode, 2'h1);
		check("open detect", det, 1'b0);
	endtask
	task automatic test_address();
		int lo;
		logic [6:0] exp;
		for (int h = 0; h < 16; h++)
			for (int k = 0; k < 2; k++)
			begin
				lo = k ? 15 - h : h;
				@(posedge clk);
				lo_i <= 4'(lo);
				hi_i <= 4'(h);
				boot();
				exp = h <= 6 ? 7'(16 * (1 + h) + lo) : (lo == 15 ? 7'h10 : 7'(16 + lo));
				check("address", addr, exp);
				check("address floor", addr >= 7'h10, 1'b1);
				check("detect", det, !(lo == 15 && h == 15));
			end
	endtask
	task automatic test_setpoint();
		logic [RES_W-1:0] v [6];
		logic [1:0] m;
		v = '{17'h00009, 17'h0000a, 17'h0493e, 17'h07530, 17'h15f90, 17'h15f91};
		@(posedge clk) lo_i <= 4'hf;
		hi_i <= 4'hf;
		foreach (v[i])
		begin
			@(posedge clk) set_r <= v[i];
			boot();
			m = v[i] < 10 ? 2'h0 : (v[i] > 90000 ? 2'h1 : 2'h2);
			check("vout", vout, m == 2'h2 ? 13'(v[i] * 4 / 75) : 13'h0258);
			check("mode", mode, m);
			check("detect", det, v[i] <= 90000);
		end
	endtask
	task automatic test_ignore();
		@(posedge clk) lo_i <= 4'h3;
		hi_i <= 4'h2;
		@(posedge clk) start_up <= 1;
		@(posedge clk) start_up <= 0;
		repeat (400) @(posedge clk);
		boot();
		check("latched", addr, 7'h33);
		@(posedge clk) lo_i <= 4'h5;
		set_r <= 17'h07530;
		repeat (400) @(posedge clk);
		#1 check("ignored", addr, 7'h33);
		check("held vout", vout, 13'h0258);
		boot();
		check("relatched", addr, 7'h35);
		check("relatched vout", vout, 13'h0640);
	endtask
	task automatic test_write();
		@(posedge clk);
		{wa_v, wv_v, wc_v} <= 3'h7;
		wa <= 7'h55;
		wv <= 13'h04d2;
		wc <= 2'h0;
		@(posedge clk) {wa_v, wv_v, wc_v} <= 3'h0;
		#1 check("wr addr", addr, 7'h55);
		check("wr vout", vout, 13'h04d2);
		check("wr mode", mode, 2'h0);
		@(posedge clk) wc_v <= 1;
		wc <= 2'h3;
		@(posedge clk) wc_v <= 0;
		#1 check("bad mode", mode, 2'h0);
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		#1 test_defaults();
		test_address();
		test_setpoint();
		test_ignore();
		test_write();
		results();
	end
endmodule
